// File: src/vsl_pkg.sv
// Shared constants and types of the VME slave lock, RMW and config block
package vsl_pkg;
  // Register offsets
  localparam logic [7:0] OFF_MON_CTL = 8'h00;
  localparam logic [7:0] OFF_MON_BASE = 8'h04;
  localparam logic [7:0] OFF_IMG_CTL = 8'h08;
  localparam logic [7:0] OFF_IMG_OFS = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  // Reset values
  localparam logic [31:0] RST_MON_CTL = 32'h0000_0000;
  localparam logic [31:0] RST_MON_BASE = 32'h0000_0000;
  localparam logic [31:0] RST_IMG_CTL = 32'h0000_0000;
  localparam logic [31:0] RST_IMG_OFS = 32'h0000_0000;
  // Monitor control fields
  localparam int MON_EN_BIT = 31;
  localparam int MON_PGM_LSB = 22;
  localparam int MON_SUP_LSB = 20;
  localparam int MON_SPACE_LSB = 16;
  localparam int MON_BASE_LSB = 12;
  // Image control fields
  localparam int IMG_LAS_LSB = 0;
  localparam int IMG_RMW_BIT = 2;
  localparam int IMG_PW_BIT = 3;
  localparam int IMG_BM_BIT = 4;
  localparam int IMG_BUS_LSB = 8;
  // Local space codes of the image
  localparam logic [1:0] LAS_MEM = 2'h0;
  localparam logic [1:0] LAS_IO = 2'h1;
  localparam logic [1:0] LAS_CFG = 2'h2;
  // VME space codes of the monitor window
  localparam logic [3:0] SPACE_A16 = 4'h0;
  localparam logic [3:0] SPACE_A24 = 4'h1;
  localparam logic [3:0] SPACE_A32 = 4'h2;
  // PCI commands
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  // Config cycle details
  localparam int DEV_LINES = 21;
  localparam logic [1:0] CFG_T0_LOW = 2'h0;
  localparam logic [1:0] CFG_T1_LOW = 2'h1;
  localparam logic [3:0] BE_ALL_N = 4'h0;
  // Channel states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01
  } vsl_state_type;
endpackage : vsl_pkg

// File: src/vsl_lm_decode.sv
// Location monitor window decode
`timescale 1ns/1ps
`default_nettype none
module vsl_lm_decode (
  // Monitor programming
  input wire logic [31:0] mon_ctl_i,
  input wire logic [31:0] mon_base_i,
  // Decoded VME cycle
  input wire logic [31:0] addr_i,
  input wire logic [3:0] space_i,
  input wire logic am_prog_i,
  input wire logic am_super_i,
  input wire logic block_i,
  // Result
  output logic hit_o,
  output logic [1:0] sel_o
);
  logic [31:0] mask;
  logic [1:0] pgm;
  logic [1:0] sup;
  logic am_ok;
  // Upper bits outside the space drop out of the compare
  always_comb begin
    case (mon_ctl_i[vsl_pkg::MON_SPACE_LSB +: 4])
      vsl_pkg::SPACE_A16: mask = 32'h0000_F000;
      vsl_pkg::SPACE_A24: mask = 32'h00FF_F000;
      default: mask = 32'hFFFF_F000;
    endcase
  end
  assign pgm = mon_ctl_i[vsl_pkg::MON_PGM_LSB +: 2];
  assign sup = mon_ctl_i[vsl_pkg::MON_SUP_LSB +: 2];
  // Bit 1 accepts program or supervisor, bit 0 data or user
  assign am_ok = (am_prog_i ? pgm[1] : pgm[0]) & (am_super_i ? sup[1] : sup[0]);
  // Block transfers never hit a monitor
  assign hit_o = mon_ctl_i[vsl_pkg::MON_EN_BIT] & am_ok & !block_i &
                 (space_i == mon_ctl_i[vsl_pkg::MON_SPACE_LSB +: 4]) &
                 ((addr_i & mask) == (mon_base_i & mask));
  assign sel_o = addr_i[4:3];
endmodule : vsl_lm_decode
`default_nettype wire

// File: src/vsl_channel.sv
// VME slave channel: lock commands, RMW mapping, monitors, config cycles
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module vsl_channel (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // Decoded VME slave cycle
  input wire logic vme_req_i,
  input wire logic [31:0] vme_addr_i,
  input wire logic vme_write_i,
  input wire logic vme_lock_cmd_i,
  input wire logic vme_block_i,
  input wire logic vme_d24_i,
  input wire logic vme_unaligned_i,
  input wire logic [3:0] vme_space_i,
  input wire logic vme_am_prog_i,
  input wire logic vme_am_super_i,
  input wire logic vme_own_master_i,
  input wire logic vme_as_n_i,
  input wire logic vme_bbsy_n_i,
  // VME cycle answer
  output logic vme_dtack_o,
  output logic vme_berr_o,
  output logic [31:0] vme_rdata_o,
  // PCI master request
  output logic pci_req_o,
  output logic [31:0] pci_addr_o,
  output logic [3:0] pci_cmd_o,
  output logic [3:0] pci_be_n_o,
  output logic pci_lock_o,
  output logic pci_posted_o,
  input wire logic pci_done_i,
  input wire logic pci_err_i,
  input wire logic [31:0] pci_rdata_i,
  // DMA hold and monitor interrupts
  output logic dma_hold_o,
  output logic [3:0] lm_irq_o
);
  vsl_pkg::vsl_state_type st_reg;
  logic [31:0] mon_ctl_reg;
  logic [31:0] mon_base_reg;
  logic [31:0] img_ctl_reg;
  logic [31:0] img_ofs_reg;
  logic lock_cmd_reg;
  logic rmw_lock_reg;
  logic rmw_pend_reg;
  logic read_reg;
  logic unl_read_reg;
  logic type1_reg;
  logic lm_hit;
  logic [1:0] lm_sel;
  logic [1:0] local_space_select;
  logic bm_on;
  logic is_cfg;
  logic is_mem;
  logic lock_ok;
  logic rmw_lock_rd;
  logic go_pci;
  logic take;
  logic lock_any;
  logic cfg_type0;
  logic [31:0] sum;
  // Width must be known before the select lines are declared
  localparam int DEV_W = vsl_pkg::DEV_LINES;
  logic [DEV_W-1:0] dev_sel;
  logic [31:0] addr_next;
  logic [3:0] cmd_next;
  logic posted_next;

  // Monitor window decode
  vsl_lm_decode u_lm (
    .mon_ctl_i(mon_ctl_reg),
    .mon_base_i(mon_base_reg),
    .addr_i(vme_addr_i),
    .space_i(vme_space_i),
    .am_prog_i(vme_am_prog_i),
    .am_super_i(vme_am_super_i),
    .block_i(vme_block_i),
    .hit_o(lm_hit),
    .sel_o(lm_sel)
  );

  // Image decode of the incoming cycle
  assign local_space_select = img_ctl_reg[vsl_pkg::IMG_LAS_LSB +: 2];
  assign bm_on = img_ctl_reg[vsl_pkg::IMG_BM_BIT];
  assign is_cfg = (local_space_select == vsl_pkg::LAS_CFG);
  assign is_mem = (local_space_select == vsl_pkg::LAS_MEM);
  assign lock_ok = vme_lock_cmd_i & bm_on & is_mem;
  // Misaligned or D24 reads stay unlocked
  assign rmw_lock_rd = !vme_write_i & !vme_block_i & !vme_lock_cmd_i & !is_cfg &
                       img_ctl_reg[vsl_pkg::IMG_RMW_BIT] &
                       !vme_d24_i & !vme_unaligned_i;
  // Refused lock commands get no answer; the VME timer ends them
  assign go_pci = bm_on & !lm_hit & (!vme_lock_cmd_i | lock_ok);
  assign take = ce_i & vme_req_i & (st_reg == vsl_pkg::ST_IDLE);
  assign lock_any = lock_cmd_reg | rmw_lock_reg;

  // Config address forming
  assign sum = vme_addr_i + img_ofs_reg;
  assign cfg_type0 = (vme_addr_i[23:16] == img_ctl_reg[vsl_pkg::IMG_BUS_LSB +: 8]);
  // One select line per device code; codes above the table drive none
  genvar gi;
  generate
    for (gi = 0; gi < DEV_W; gi++) begin : g_dev
      assign dev_sel[gi] = (vme_addr_i[15:11] == 5'(gi));
    end
  endgenerate

  // Address, command and posting of the next PCI request
  always_comb begin
    if (is_cfg && cfg_type0) begin
      addr_next = {dev_sel, vme_addr_i[10:2], vsl_pkg::CFG_T0_LOW};
    end else if (is_cfg) begin
      addr_next = {sum[31:2], vsl_pkg::CFG_T1_LOW};
    end else begin
      addr_next = sum;
    end
    if (is_cfg && !vme_lock_cmd_i) begin
      cmd_next = vme_write_i ? vsl_pkg::CMD_CFG_WR : vsl_pkg::CMD_CFG_RD;
    end else if (vme_write_i && !vme_lock_cmd_i) begin
      cmd_next = vsl_pkg::CMD_MEM_WR;
    end else begin
      cmd_next = vsl_pkg::CMD_MEM_RD;
    end
    // Any lock forces coupling, so nothing posts while locked
    posted_next = vme_write_i & !vme_lock_cmd_i & !lock_any & !is_cfg &
                  img_ctl_reg[vsl_pkg::IMG_PW_BIT];
  end

  // Register writes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mon_ctl_reg <= vsl_pkg::RST_MON_CTL;
      mon_base_reg <= vsl_pkg::RST_MON_BASE;
      img_ctl_reg <= vsl_pkg::RST_IMG_CTL;
      img_ofs_reg <= vsl_pkg::RST_IMG_OFS;
    end else if (ce_i && reg_we_i) begin
      case (reg_addr_i)
        vsl_pkg::OFF_MON_CTL: mon_ctl_reg <= reg_wdata_i;
        vsl_pkg::OFF_MON_BASE: mon_base_reg <= reg_wdata_i;
        vsl_pkg::OFF_IMG_CTL: img_ctl_reg <= reg_wdata_i;
        vsl_pkg::OFF_IMG_OFS: img_ofs_reg <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Register reads, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      reg_rdata_o <= 32'h0000_0000;
      if (reg_re_i) begin
        case (reg_addr_i)
          vsl_pkg::OFF_MON_CTL: reg_rdata_o <= mon_ctl_reg;
          vsl_pkg::OFF_MON_BASE: reg_rdata_o <= {mon_base_reg[31:12], 12'h000};
          vsl_pkg::OFF_IMG_CTL: reg_rdata_o <= img_ctl_reg;
          vsl_pkg::OFF_IMG_OFS: reg_rdata_o <= img_ofs_reg;
          vsl_pkg::OFF_STATUS: reg_rdata_o <= {27'h0, type1_reg, st_reg[0],
                                               rmw_pend_reg, rmw_lock_reg, lock_cmd_reg};
          default: reg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Channel sequencing and PCI request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= vsl_pkg::ST_IDLE;
      pci_req_o <= 1'b0;
      pci_addr_o <= 32'h0000_0000;
      pci_cmd_o <= vsl_pkg::CMD_MEM_RD;
      pci_be_n_o <= vsl_pkg::BE_ALL_N;
      pci_posted_o <= 1'b0;
      read_reg <= 1'b0;
      unl_read_reg <= 1'b0;
      type1_reg <= 1'b0;
    end else if (ce_i) begin
      case (st_reg)
        vsl_pkg::ST_IDLE: begin
          if (take && go_pci) begin
            st_reg <= vsl_pkg::ST_BUSY;
            pci_req_o <= 1'b1;
            pci_addr_o <= addr_next;
            pci_cmd_o <= cmd_next;
            pci_be_n_o <= vsl_pkg::BE_ALL_N;
            pci_posted_o <= posted_next;
            read_reg <= !vme_write_i & !vme_lock_cmd_i;
            unl_read_reg <= !vme_write_i & !vme_block_i & !vme_lock_cmd_i &
                            !rmw_lock_rd & !is_cfg;
            type1_reg <= is_cfg & !cfg_type0;
          end
        end
        vsl_pkg::ST_BUSY: begin
          if (pci_done_i) begin
            st_reg <= vsl_pkg::ST_IDLE;
            pci_req_o <= 1'b0;
            pci_posted_o <= 1'b0;
          end
        end
        default: begin
          st_reg <= vsl_pkg::ST_IDLE;
          pci_req_o <= 1'b0;
        end
      endcase
    end
  end

  // VME answers; posted writes answer at once, coupled ones at PCI end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vme_dtack_o <= 1'b0;
      vme_berr_o <= 1'b0;
      vme_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      vme_dtack_o <= 1'b0;
      vme_berr_o <= 1'b0;
      if (take && lm_hit) begin
        vme_dtack_o <= vme_own_master_i;
      end else if (take && go_pci && posted_next) begin
        vme_dtack_o <= 1'b1;
      end else if (st_reg == vsl_pkg::ST_BUSY && pci_done_i && !pci_posted_o) begin
        vme_dtack_o <= !pci_err_i;
        vme_berr_o <= pci_err_i;
        if (read_reg && !pci_err_i) begin
          vme_rdata_o <= pci_rdata_i;
        end
      end
    end
  end

  // Lock ownership; a new take wins over a same-cycle release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_cmd_reg <= 1'b0;
      rmw_lock_reg <= 1'b0;
    end else if (ce_i) begin
      if (take && lock_ok && !lm_hit) begin
        lock_cmd_reg <= 1'b1;
      end else if (vme_bbsy_n_i) begin
        lock_cmd_reg <= 1'b0;
      end
      if (take && go_pci && rmw_lock_rd) begin
        rmw_lock_reg <= 1'b1;
      end else if (vme_as_n_i && st_reg == vsl_pkg::ST_IDLE) begin
        rmw_lock_reg <= 1'b0;
      end
    end
  end

  // Gap between an unlocked RMW read and its write; set wins over clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rmw_pend_reg <= 1'b0;
    end else if (ce_i) begin
      if (st_reg == vsl_pkg::ST_BUSY && pci_done_i && unl_read_reg) begin
        rmw_pend_reg <= 1'b1;
      end else if (vme_as_n_i ||
                   (st_reg == vsl_pkg::ST_BUSY && pci_done_i && !read_reg)) begin
        rmw_pend_reg <= 1'b0;
      end
    end
  end

  // Monitor interrupts, one pulse per hit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lm_irq_o <= 4'h0;
    end else if (ce_i) begin
      lm_irq_o <= (take && lm_hit) ? (4'h1 << lm_sel) : 4'h0;
    end
  end

  // Lock covers the whole locked read, not only after it ends
  assign pci_lock_o = lock_any;
  // DMA waits on any lock or open RMW gap
  assign dma_hold_o = lock_any | rmw_pend_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  lock_read_a: assert property (take && lock_ok && !lm_hit |=>
    pci_req_o && pci_lock_o && pci_cmd_o == vsl_pkg::CMD_MEM_RD && pci_be_n_o == 4'h0)
    else $error("lock command did not start a locked read");
  lock_hold_a: assert property (lock_cmd_reg && !vme_bbsy_n_i |=> lock_cmd_reg)
    else $error("lock dropped while BBSY held");
  no_post_lock_a: assert property (pci_req_o && $rose(pci_req_o) && $past(lock_any) |->
    !pci_posted_o)
    else $error("write posted while locked");
  lock_gate_a: assert property (take && vme_lock_cmd_i && !(bm_on && is_mem) |=>
    !pci_req_o && !lock_cmd_reg)
    else $error("lock command accepted without mastering or memory image");
  coupled_err_a: assert property (st_reg == vsl_pkg::ST_BUSY && pci_done_i && pci_err_i &&
    !pci_posted_o && ce_i |=> vme_berr_o && !vme_dtack_o)
    else $error("PCI error not reported as VME bus error");
  dma_hold_a: assert property ((take && lock_ok && !lm_hit) ||
    (ce_i && unl_read_reg && st_reg == vsl_pkg::ST_BUSY && pci_done_i) |=> dma_hold_o)
    else $error("DMA not held during lock or RMW gap");
  as_release_a: assert property (rmw_lock_reg && !lock_cmd_reg && vme_as_n_i && ce_i &&
    st_reg == vsl_pkg::ST_IDLE && !take |=> !pci_lock_o)
    else $error("RMW lock not freed at AS negation");
  rmw_map_a: assert property (take && go_pci && rmw_lock_rd |=> pci_lock_o && pci_req_o)
    else $error("single read not mapped to locked read");
  lm_irq_a: assert property (take && lm_hit |=> lm_irq_o == (4'h1 << $past(vme_addr_i[4:3])))
    else $error("wrong monitor interrupt");
  own_dtack_a: assert property (take && lm_hit && !vme_own_master_i |=> !vme_dtack_o && !pci_req_o)
    else $error("acknowledged foreign monitor hit");
  type0_sel_a: assert property (take && go_pci && is_cfg && cfg_type0 |=>
    $onehot0(pci_addr_o[31:11]) && pci_addr_o[1:0] == 2'b00)
    else $error("type 0 select lines not one-hot");

  lock_cmd_c: cover property (take && lock_ok ##[1:20] vme_dtack_o);
  lm_hit_c: cover property (take && lm_hit && vme_own_master_i ##1 vme_dtack_o);
  cfg_t1_c: cover property (take && is_cfg && !cfg_type0 ##[1:20] pci_done_i);
  rmw_gap_c: cover property (rmw_pend_reg ##[1:30] !rmw_pend_reg);
endmodule : vsl_channel
`default_nettype wire

// File: dv/vsl_pci_target.sv
// Behavioural PCI target that answers the channel's single-beat requests
`timescale 1ns/1ps
`default_nettype none
module vsl_pci_target #(
  parameter logic [31:0] READ_WORD = 32'hC0DE_0123
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Request from the channel and test controls
  input wire logic req_i,
  input wire logic err_cmd_i,
  input wire logic [3:0] lat_i,
  // Answer
  output logic done_o,
  output logic err_o,
  output logic [31:0] rdata_o
);
  logic [3:0] wait_reg;
  logic answered_reg;
  // One answer per request; data toggles outside the done cycle so stale data never looks valid
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      wait_reg <= 4'h0;
      answered_reg <= 1'b0;
    end else begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (!req_i) begin
        wait_reg <= 4'h0;
        answered_reg <= 1'b0;
      end else if (!answered_reg) begin
        if (wait_reg == lat_i) begin
          done_o <= 1'b1;
          err_o <= err_cmd_i;
          rdata_o <= READ_WORD;
          answered_reg <= 1'b1;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
endmodule : vsl_pci_target
`default_nettype wire

// File: dv/vme_slave_lock_rmw_cfg_bench.sv
// Self-checking bench of the VME slave lock, RMW, monitor and config channel
`timescale 1ns/1ps
`default_nettype none
module vme_slave_lock_rmw_cfg_bench;
  logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o, vme_addr_i = 32'h0000_0000;
  logic reg_we_i = 1'b0, reg_re_i = 1'b0, vme_req_i = 1'b0, vme_write_i = 1'b0;
  logic vme_lock_cmd_i = 1'b0, vme_block_i = 1'b0, vme_d24_i = 1'b0, vme_unaligned_i = 1'b0;
  logic [3:0] vme_space_i = vsl_pkg::SPACE_A32;
  logic vme_am_prog_i = 1'b1, vme_am_super_i = 1'b1, vme_own_master_i = 1'b0;
  logic vme_as_n_i = 1'b1, vme_bbsy_n_i = 1'b1;
  logic vme_dtack_o, vme_berr_o, pci_req_o, pci_lock_o, pci_posted_o, dma_hold_o;
  logic [31:0] vme_rdata_o, pci_addr_o, pci_rdata_i;
  logic [3:0] pci_cmd_o, pci_be_n_o, lm_irq_o;
  logic pci_done_i, pci_err_i, err_cmd = 1'b0;
  logic [3:0] lat = 4'h0;
  // Results of the last VME cycle
  logic ack, ber, rq, lks, ps;
  logic [31:0] pa, rdat, rv;
  logic [3:0] cm, be, irq;
  int num_errors = 0, tests_run = 0, cycles = 0;

  vsl_channel dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .vme_req_i(vme_req_i), .vme_addr_i(vme_addr_i),
    .vme_write_i(vme_write_i), .vme_lock_cmd_i(vme_lock_cmd_i), .vme_block_i(vme_block_i),
    .vme_d24_i(vme_d24_i), .vme_unaligned_i(vme_unaligned_i), .vme_space_i(vme_space_i),
    .vme_am_prog_i(vme_am_prog_i), .vme_am_super_i(vme_am_super_i),
    .vme_own_master_i(vme_own_master_i), .vme_as_n_i(vme_as_n_i), .vme_bbsy_n_i(vme_bbsy_n_i),
    .vme_dtack_o(vme_dtack_o), .vme_berr_o(vme_berr_o), .vme_rdata_o(vme_rdata_o),
    .pci_req_o(pci_req_o), .pci_addr_o(pci_addr_o), .pci_cmd_o(pci_cmd_o),
    .pci_be_n_o(pci_be_n_o), .pci_lock_o(pci_lock_o), .pci_posted_o(pci_posted_o),
    .pci_done_i(pci_done_i), .pci_err_i(pci_err_i), .pci_rdata_i(pci_rdata_i),
    .dma_hold_o(dma_hold_o), .lm_irq_o(lm_irq_o));
  vsl_pci_target target (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(pci_req_o),
    .err_cmd_i(err_cmd), .lat_i(lat), .done_o(pci_done_i), .err_o(pci_err_i),
    .rdata_o(pci_rdata_i));

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 rv = reg_rdata_o;
  endtask : rd

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_n

  task automatic as_off();
    @(posedge clk_i);
    vme_as_n_i <= 1'b1;
  endtask : as_off

  // One decoded VME cycle; AS stays low until the caller lets it go
  task automatic vcyc(input logic [31:0] a, input logic w, input logic lk, input logic own);
    @(posedge clk_i);
    vme_req_i <= 1'b1;
    vme_addr_i <= a;
    vme_write_i <= w;
    vme_lock_cmd_i <= lk;
    vme_own_master_i <= own;
    vme_as_n_i <= 1'b0;
    {ack, ber, rq, lks, ps, irq} = 9'h000;
    @(posedge clk_i);
    vme_req_i <= 1'b0;
    for (int i = 0; i < 30 && !(ack || ber); i++) begin
      #1;
      if (pci_req_o === 1'b1) begin
        rq = 1'b1;
        pa = pci_addr_o;
        cm = pci_cmd_o;
        be = pci_be_n_o;
        lks = pci_lock_o;
        ps = pci_posted_o;
      end
      irq = irq | lm_irq_o;
      ack = (vme_dtack_o === 1'b1);
      ber = (vme_berr_o === 1'b1);
      rdat = vme_rdata_o;
      if (!(ack || ber)) @(posedge clk_i);
    end
  endtask : vcyc

  task automatic t_regs();
    rd(vsl_pkg::OFF_MON_CTL);
    chk("mon_ctl reset", rv, vsl_pkg::RST_MON_CTL);
    // A write while the enable is low must not land
    ce_i <= 1'b0;
    wr(vsl_pkg::OFF_IMG_OFS, 32'h0000_00FF);
    ce_i <= 1'b1;
    rd(vsl_pkg::OFF_IMG_OFS);
    chk("offset reset", rv, vsl_pkg::RST_IMG_OFS);
    wr(vsl_pkg::OFF_MON_BASE, 32'hABCD_EFFF);
    rd(vsl_pkg::OFF_MON_BASE);
    chk("mon_base rw", rv, 32'hABCD_E000);
    rd(8'h40);
    chk("unmapped read", rv, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_cfg();
    logic [4:0] codes [3] = '{5'h00, 5'h05, 5'h14};
    logic [31:0] a;
    wr(vsl_pkg::OFF_IMG_CTL, 32'h0000_1212);
    wr(vsl_pkg::OFF_IMG_OFS, 32'h0000_0000);
    foreach (codes[k]) begin
      a = {16'h0012, codes[k], 11'h25C};
      vcyc(a, k == 2, 1'b0, 1'b1);
      as_off();
      chk("type0 addr", pa, (32'h1 << (11 + codes[k])) | 32'h0000_025C);
      chk("cfg cmd", cm, (k == 2) ? vsl_pkg::CMD_CFG_WR : vsl_pkg::CMD_CFG_RD);
      chk("cfg ack", ack, 1'b1);
    end
    wr(vsl_pkg::OFF_IMG_OFS, 32'h0000_0100);
    a = 32'h0034_2A5C + 32'h0000_0100;
    vcyc(32'h0034_2A5C, 1'b0, 1'b0, 1'b1);
    as_off();
    chk("type1 addr", pa, {a[31:2], 2'b01});
    $display("test cfg done");
  endtask : t_cfg

  task automatic t_lock();
    lat <= 4'h3;
    wr(vsl_pkg::OFF_IMG_CTL, 32'h0000_0018);
    vme_bbsy_n_i <= 1'b0;
    vcyc(32'h1000_0000, 1'b0, 1'b1, 1'b1);
    chk("lock cmd", cm, vsl_pkg::CMD_MEM_RD);
    chk("lock be", be, vsl_pkg::BE_ALL_N);
    chk("lock seen", lks, 1'b1);
    as_off();
    wait_n(2);
    chk("lock after AS", pci_lock_o, 1'b1);
    chk("dma hold", dma_hold_o, 1'b1);
    err_cmd <= 1'b1;
    vcyc(32'h1000_0004, 1'b1, 1'b0, 1'b1);
    chk("locked write coupled", rq, 1'b1);
    chk("locked not posted", ps, 1'b0);
    chk("locked berr", ber, 1'b1);
    as_off();
    err_cmd <= 1'b0;
    vme_bbsy_n_i <= 1'b1;
    wait_n(2);
    chk("lock released", pci_lock_o, 1'b0);
    chk("dma free", dma_hold_o, 1'b0);
    lat <= 4'h0;
    // Lock gone, so the posting image answers a write at once
    vcyc(32'h1000_0008, 1'b1, 1'b0, 1'b1);
    as_off();
    chk("posted write", ps, 1'b1);
    chk("posted ack", ack, 1'b1);
    $display("test lock done");
  endtask : t_lock

  task automatic t_refuse();
    logic [31:0] ctl [2] = '{32'h0000_0000, 32'h0000_0011};
    foreach (ctl[k]) begin
      wr(vsl_pkg::OFF_IMG_CTL, ctl[k]);
      vme_bbsy_n_i <= 1'b0;
      vcyc(32'h1000_0000, 1'b0, 1'b1, 1'b1);
      chk("refused lock req", rq, 1'b0);
      chk("refused lock", pci_lock_o, 1'b0);
      as_off();
      vme_bbsy_n_i <= 1'b1;
    end
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_rmw();
    wr(vsl_pkg::OFF_IMG_CTL, 32'h0000_0014);
    vcyc(32'h2000_0010, 1'b0, 1'b0, 1'b1);
    chk("rmw locked read", lks, 1'b1);
    chk("rmw data", rdat, 32'hC0DE_0123);
    as_off();
    wait_n(2);
    chk("rmw lock drop", pci_lock_o, 1'b0);
    vme_d24_i <= 1'b1;
    vcyc(32'h2000_0010, 1'b0, 1'b0, 1'b1);
    as_off();
    vme_d24_i <= 1'b0;
    chk("d24 unlocked", lks, 1'b0);
    wr(vsl_pkg::OFF_IMG_CTL, 32'h0000_0010);
    vcyc(32'h2000_0010, 1'b0, 1'b0, 1'b1);
    chk("plain read unlocked", lks, 1'b0);
    chk("gap hold", dma_hold_o, 1'b1);
    vcyc(32'h2000_0010, 1'b1, 1'b0, 1'b1);
    chk("rmw write cmd", cm, vsl_pkg::CMD_MEM_WR);
    wait_n(1);
    chk("gap closed", dma_hold_o, 1'b0);
    as_off();
    $display("test rmw done");
  endtask : t_rmw

  task automatic t_mon();
    wr(vsl_pkg::OFF_MON_CTL, 32'h80F2_0000);
    wr(vsl_pkg::OFF_MON_BASE, 32'hABCD_E000);
    for (int k = 0; k < 4; k++) begin
      vcyc(32'hABCD_E000 | (k << 3), 1'b0, 1'b0, 1'b0);
      as_off();
      chk("monitor irq", irq, 4'h1 << k);
      chk("foreign no ack", ack, 1'b0);
    end
    vcyc(32'hABCD_EFF8, 1'b1, 1'b0, 1'b1);
    as_off();
    chk("own ack", ack, 1'b1);
    chk("own irq", irq, 4'h8);
    vcyc(32'hABCD_F000, 1'b0, 1'b0, 1'b0);
    as_off();
    chk("outside window", irq, 4'h0);
    vme_block_i <= 1'b1;
    vcyc(32'hABCD_E000, 1'b0, 1'b0, 1'b0);
    as_off();
    chk("block ignored", irq, 4'h0);
    vme_block_i <= 1'b0;
    vme_space_i <= vsl_pkg::SPACE_A24;
    vcyc(32'hABCD_E000, 1'b0, 1'b0, 1'b0);
    as_off();
    chk("space miss", irq, 4'h0);
    vme_space_i <= vsl_pkg::SPACE_A32;
    $display("test monitor done");
  endtask : t_mon

  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_cfg();
    t_lock();
    t_refuse();
    t_rmw();
    t_mon();
    summarize();
  end
endmodule : vme_slave_lock_rmw_cfg_bench
`default_nettype wire
